// ### rr_exec_pkg.sv
// constants, types and encodings for the return and rotate execution unit
package rr_exec_pkg;

   // instruction word layout
   localparam int INSTR_W = 14;
   localparam int OP_MSB = 13;
   localparam int OP_LSB = 8;
   localparam int DEST_BIT = 7;
   localparam int FADDR_W = 7;
   localparam int LIT_W = 8;

   // opcode field values
   localparam logic [5:0] OP_RETURN_WITH_LITERAL = 6'h01;
   localparam logic [5:0] OP_RETURN = 6'h02;
   localparam logic [5:0] OP_ROTATE_LEFT = 6'h03;
   localparam logic [5:0] OP_ROTATE_RIGHT = 6'h04;

   // destination select values
   localparam logic DEST_W = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // reset values
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic CARRY_RESET = 1'b0;

   // decoded operation
   typedef enum logic [2:0] {
      OPK_NONE = 3'b000,
      OPK_RET_LIT = 3'b001,
      OPK_RET = 3'b010,
      OPK_ROT_L = 3'b011,
      OPK_ROT_R = 3'b100
   } op_kind_t;

   // sequencing state
   typedef enum logic {
      ST_RUN = 1'b0,
      ST_RET_EXEC = 1'b1
   } state_t;

   // execute-stage contents
   typedef struct packed {
      logic valid;
      op_kind_t kind;
      logic dest;
      logic [7:0] lit;
   } exec_stage_t;

endpackage

// ### return_and_rotate_execution.sv
// execution unit for the two returns and the two rotates through carry
`timescale 1ns/100ps
module return_and_rotate_execution #(
   parameter int PC_W = 15,
   parameter int BANK_W = 6
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // instruction issue
   input wire logic instr_valid_in,
   input wire logic [rr_exec_pkg::INSTR_W-1:0] instr_in,
   input wire logic [BANK_W-1:0] bank_sel_in,
   output logic ready_out,
   // return stack
   input wire logic [PC_W-1:0] stack_top_entry_in,
   output logic stack_pop_out,
   output logic pc_load_out,
   output logic [PC_W-1:0] pc_out,
   // core state
   output logic [7:0] w_out,
   output logic carry_out,
   // data memory
   output logic [BANK_W+rr_exec_pkg::FADDR_W-1:0] file_raddr_out,
   input wire logic [7:0] file_rdata_in,
   output logic file_wr_out,
   output logic [BANK_W+rr_exec_pkg::FADDR_W-1:0] file_waddr_out,
   output logic [7:0] file_wdata_out
);

   localparam int ADDR_W = BANK_W + rr_exec_pkg::FADDR_W;

   // opcode field to operation
   function automatic rr_exec_pkg::op_kind_t decode(
      input logic [rr_exec_pkg::INSTR_W-1:0] instr
   );
      logic [5:0] op;
      op = instr[rr_exec_pkg::OP_MSB:rr_exec_pkg::OP_LSB];
      case (op)
         rr_exec_pkg::OP_RETURN_WITH_LITERAL:
            decode = rr_exec_pkg::OPK_RET_LIT;
         rr_exec_pkg::OP_RETURN: decode = rr_exec_pkg::OPK_RET;
         rr_exec_pkg::OP_ROTATE_LEFT: decode = rr_exec_pkg::OPK_ROT_L;
         rr_exec_pkg::OP_ROTATE_RIGHT: decode = rr_exec_pkg::OPK_ROT_R;
         default: decode = rr_exec_pkg::OPK_NONE;
      endcase
   endfunction

   // rotate through carry, returns {new carry, result}
   function automatic logic [8:0] rotate(
      input logic [7:0] data,
      input logic cin,
      input logic left
   );
      if (left) begin
         rotate = {data[7], data[6:0], cin};
      end else begin
         rotate = {data[0], cin, data[7:1]};
      end
   endfunction

   rr_exec_pkg::state_t state_reg, state_next;
   rr_exec_pkg::exec_stage_t ex_reg, ex_next;
   rr_exec_pkg::op_kind_t kind_in;
   logic accept;
   logic ready_reg, ready_next;
   logic [ADDR_W-1:0] raddr_reg, raddr_next;
   logic [7:0] w_reg, w_next;
   logic carry_reg, carry_next;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic pop_reg, pop_next;
   logic pc_load_reg, pc_load_next;
   logic wr_reg, wr_next;
   logic [ADDR_W-1:0] waddr_reg, waddr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic [7:0] operand;
   logic [8:0] rot_res;

   // issue: a return blocks the next issue for one cycle
   always_comb begin
      kind_in = decode(instr_in);
      accept = ready_reg && instr_valid_in;
      state_next = rr_exec_pkg::ST_RUN;
      case (state_reg)
         rr_exec_pkg::ST_RUN: begin
            if (accept && (kind_in == rr_exec_pkg::OPK_RET_LIT ||
                           kind_in == rr_exec_pkg::OPK_RET)) begin
               state_next = rr_exec_pkg::ST_RET_EXEC;
            end
         end
         rr_exec_pkg::ST_RET_EXEC: state_next = rr_exec_pkg::ST_RUN;
         default: state_next = rr_exec_pkg::ST_RUN;
      endcase
      ready_next = (state_next == rr_exec_pkg::ST_RUN);
      ex_next.valid = accept && (kind_in != rr_exec_pkg::OPK_NONE);
      ex_next.kind = kind_in;
      ex_next.dest = instr_in[rr_exec_pkg::DEST_BIT];
      ex_next.lit = instr_in[rr_exec_pkg::LIT_W-1:0];
      // bank selects the page, the field the offset within it
      raddr_next = accept ?
         {bank_sel_in, instr_in[rr_exec_pkg::FADDR_W-1:0]} : raddr_reg;
   end

   // issue registers
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= rr_exec_pkg::ST_RUN;
         ready_reg <= 1'b1;
         ex_reg <= '0;
         raddr_reg <= '0;
      end else begin
         state_reg <= state_next;
         ready_reg <= ready_next;
         ex_reg <= ex_next;
         raddr_reg <= raddr_next;
      end
   end

   // execute: forwarding covers a write-back still in flight to memory
   always_comb begin
      operand = (wr_reg && waddr_reg == raddr_reg) ? wdata_reg : file_rdata_in;
      rot_res = rotate(operand, carry_reg,
                       ex_reg.kind == rr_exec_pkg::OPK_ROT_L);
      w_next = w_reg;
      carry_next = carry_reg;
      pc_next = pc_reg;
      pop_next = 1'b0;
      pc_load_next = 1'b0;
      wr_next = 1'b0;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      if (ex_reg.valid) begin
         case (ex_reg.kind)
            rr_exec_pkg::OPK_RET_LIT: begin
               w_next = ex_reg.lit;
               pc_next = stack_top_entry_in;
               pop_next = 1'b1;
               pc_load_next = 1'b1;
            end
            rr_exec_pkg::OPK_RET: begin
               pc_next = stack_top_entry_in;
               pop_next = 1'b1;
               pc_load_next = 1'b1;
            end
            rr_exec_pkg::OPK_ROT_L, rr_exec_pkg::OPK_ROT_R: begin
               carry_next = rot_res[8];
               if (ex_reg.dest == rr_exec_pkg::DEST_W) begin
                  w_next = rot_res[7:0];
               end else begin
                  wr_next = 1'b1;
                  waddr_next = raddr_reg;
                  wdata_next = rot_res[7:0];
               end
            end
            default: begin
               w_next = w_reg;
            end
         endcase
      end
   end

   // core state and memory write registers
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         w_reg <= rr_exec_pkg::W_RESET;
         carry_reg <= rr_exec_pkg::CARRY_RESET;
         pc_reg <= '0;
         pop_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         wr_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= 8'h00;
      end else begin
         w_reg <= w_next;
         carry_reg <= carry_next;
         pc_reg <= pc_next;
         pop_reg <= pop_next;
         pc_load_reg <= pc_load_next;
         wr_reg <= wr_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
      end
   end

   // outputs straight from flip-flops
   assign ready_out = ready_reg;
   assign stack_pop_out = pop_reg;
   assign pc_load_out = pc_load_reg;
   assign pc_out = pc_reg;
   assign w_out = w_reg;
   assign carry_out = carry_reg;
   assign file_raddr_out = raddr_reg;
   assign file_wr_out = wr_reg;
   assign file_waddr_out = waddr_reg;
   assign file_wdata_out = wdata_reg;

   // checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   logic is_rot;
   assign is_rot = ex_reg.valid && (ex_reg.kind == rr_exec_pkg::OPK_ROT_L ||
                                    ex_reg.kind == rr_exec_pkg::OPK_ROT_R);

   sequence ret_issue_s;
      ready_out && instr_valid_in &&
      (kind_in == rr_exec_pkg::OPK_RET || kind_in == rr_exec_pkg::OPK_RET_LIT);
   endsequence
   sequence ret_stall_s;
      !ready_out && stack_pop_out == 1'b0 ##1 ready_out && stack_pop_out;
   endsequence

   ret_lit_w_a: assert property (
      ex_reg.valid && ex_reg.kind == rr_exec_pkg::OPK_RET_LIT |=>
      w_out == $past(ex_reg.lit) && $stable(carry_out))
      else $error("literal return did not load W");
   ret_lit_pc_a: assert property (
      ex_reg.valid && ex_reg.kind == rr_exec_pkg::OPK_RET_LIT |=>
      pc_load_out && pc_out == $past(stack_top_entry_in))
      else $error("literal return did not load PC");
   ret_two_cycle_a: assert property (
      ret_issue_s |=> ret_stall_s)
      else $error("return did not take two cycles");
   ret_pop_a: assert property (
      ex_reg.valid && ex_reg.kind == rr_exec_pkg::OPK_RET |=>
      stack_pop_out && pc_out == $past(stack_top_entry_in) &&
      $stable(carry_out) && $stable(w_out) ##1 !stack_pop_out)
      else $error("plain return pop wrong");
   rot_left_a: assert property (
      is_rot && ex_reg.kind == rr_exec_pkg::OPK_ROT_L |=>
      carry_out == $past(operand[7]) &&
      (file_wr_out ? file_wdata_out : w_out) ==
      {$past(operand[6:0]), $past(carry_out)})
      else $error("rotate left result wrong");
   // a rotate must never open a stall slot behind it
   rot_one_cycle_a: assert property (
      ready_out && instr_valid_in && (kind_in == rr_exec_pkg::OPK_ROT_L ||
      kind_in == rr_exec_pkg::OPK_ROT_R) |=> ready_out)
      else $error("rotate stalled issue");
   rot_right_a: assert property (
      is_rot && ex_reg.kind == rr_exec_pkg::OPK_ROT_R &&
      ex_reg.dest == rr_exec_pkg::DEST_W |=>
      carry_out == $past(operand[0]) &&
      w_out == {$past(carry_out), $past(operand[7:1])})
      else $error("rotate right result wrong");
   dest_w_a: assert property (
      is_rot && ex_reg.dest == rr_exec_pkg::DEST_W |=> !file_wr_out)
      else $error("rotate to W wrote memory");
   rot_same_addr_a: assert property (
      is_rot && ex_reg.dest == rr_exec_pkg::DEST_FILE |=>
      file_wr_out && file_waddr_out == $past(file_raddr_out) &&
      $stable(w_out))
      else $error("write-back address wrong");
   addr_form_a: assert property (
      ready_out && instr_valid_in |=>
      file_raddr_out == {$past(bank_sel_in), $past(instr_in[6:0])})
      else $error("file address not bank plus field");

endmodule // return_and_rotate_execution

// ### return_and_rotate_execution_test.sv
// self-checking bench for the return and rotate execution unit
`timescale 1ns/100ps
module return_and_rotate_execution_test;
   typedef struct packed {
      int due;
      logic pop;
      logic wr;
      logic [12:0] wa;
      logic [7:0] wd;
      logic [7:0] w;
      logic c;
      logic [14:0] pc;
   } exp_t;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic instr_valid_in = 1'b0;
   logic [13:0] instr_in = 14'h0000;
   logic [5:0] bank_sel_in = 6'h00;
   logic [14:0] stack_top_entry_in = 15'h0000;
   logic [7:0] file_rdata_in;
   logic ready_out, stack_pop_out, pc_load_out, carry_out, file_wr_out;
   logic [14:0] pc_out;
   logic [7:0] w_out, file_wdata_out;
   logic [12:0] file_raddr_out, file_waddr_out;
   logic [7:0] mem [0:8191];
   logic [7:0] mmem [0:8191];
   logic [7:0] mw = 8'h00, vw = 8'h00;
   logic mc = 1'b0, vc = 1'b0;
   exp_t q[$];
   exp_t e, m;
   int fails = 0, total_checks = 0, cyc = 0, seed = 32'hd9c0;
   logic [31:0] rnd;

   return_and_rotate_execution #(.PC_W(15), .BANK_W(6))
      return_and_rotate_execution_inst (.clk_sys_in(clk_sys_in),
      .rst_in(rst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
      .bank_sel_in(bank_sel_in), .ready_out(ready_out),
      .stack_top_entry_in(stack_top_entry_in), .stack_pop_out(stack_pop_out),
      .pc_load_out(pc_load_out), .pc_out(pc_out), .w_out(w_out),
      .carry_out(carry_out), .file_raddr_out(file_raddr_out),
      .file_rdata_in(file_rdata_in), .file_wr_out(file_wr_out),
      .file_waddr_out(file_waddr_out), .file_wdata_out(file_wdata_out));

   // clock, 10 ns period
   always #5 clk_sys_in = ~clk_sys_in;

   // cycle count; a hang is cut short well past the expected run
   always @(posedge clk_sys_in) begin
      cyc = cyc + 1;
      if (cyc > 3000) begin
         fails++;
         complete_run();
      end
   end

   // data memory with combinational read, as the unit expects
   always @(posedge clk_sys_in) if (file_wr_out === 1'b1) begin
      mem[file_waddr_out] <= file_wdata_out;
   end
   assign file_rdata_in = mem[file_raddr_out];

   task check_val(input logic [15:0] got, input logic [15:0] exp, string s);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s", $time, s);
      end
   endtask

   task check_pulse(input logic got, input logic exp, input string s);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: strobe %s", $time, s);
      end
   endtask

   // results are due two falling edges after the offer; strobes idle else
   always @(negedge clk_sys_in) if (rst_in === 1'b0) begin
      m = '0;
      if (q.size() > 0 && q[0].due == cyc) begin
         m = q.pop_front();
         vw = m.w;
         vc = m.c;
      end
      if (m.pop) check_val(16'(pc_out), 16'(m.pc), "pc");
      if (m.wr) begin
         check_val(16'(file_waddr_out), 16'(m.wa), "waddr");
         check_val(16'(file_wdata_out), 16'(m.wd), "wdata");
      end
      check_pulse(stack_pop_out, m.pop, "pop");
      check_pulse(pc_load_out, m.pop, "pc load");
      check_pulse(file_wr_out, m.wr, "write");
      check_val(16'(w_out), 16'(vw), "w");
      check_pulse(carry_out, vc, "carry");
   end

   // offer one word, held until taken, and update the reference model
   task issue(input logic [5:0] op, input logic d, input logic [5:0] b,
              input logic [6:0] f, input logic [7:0] k);
      logic [12:0] a;
      logic [7:0] v;
      logic [7:0] r;
      @(negedge clk_sys_in);
      rnd = $random(seed);
      instr_valid_in = 1'b1;
      instr_in = {op, (op < 6'h03) ? k : {d, f}};
      bank_sel_in = b;
      if (op < 6'h03) stack_top_entry_in = rnd[30:16];
      check_pulse(ready_out, 1'b1, "ready");
      for (int i = 0; i < 4 && ready_out !== 1'b1; i++) @(negedge clk_sys_in);
      a = {b, f};
      e = '0;
      e.due = cyc + 2;
      if (op == 6'h01) mw = k;
      if (op == 6'h03 || op == 6'h04) begin
         v = mmem[a];
         r = (op == 6'h03) ? {v[6:0], mc} : {mc, v[7:1]};
         mc = (op == 6'h03) ? v[7] : v[0];
         e.wr = d;
         e.wa = a;
         e.wd = r;
         if (d) mmem[a] = r;
         else mw = r;
      end
      e.pop = (op == 6'h01 || op == 6'h02);
      e.pc = stack_top_entry_in;
      e.w = mw;
      e.c = mc;
      if (op >= 6'h01 && op <= 6'h04) q.push_back(e);
      // the word stays offered through the stall and must be refused
      if (e.pop) begin
         @(negedge clk_sys_in);
         check_pulse(ready_out, 1'b0, "stall");
      end
   endtask

   task idle();
      @(negedge clk_sys_in);
      instr_valid_in = 1'b0;
      repeat (4) @(negedge clk_sys_in);
   endtask

   task complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // main sequence: reset, directed corners, then random traffic
   initial begin
      for (int i = 0; i < 8192; i++) begin
         rnd = $random(seed);
         mem[i] = rnd[7:0];
         mmem[i] = rnd[7:0];
      end
      mem[13'h0085] = 8'he6;
      mmem[13'h0085] = 8'he6;
      repeat (12) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      check_val({carry_out, stack_pop_out, pc_load_out, file_wr_out,
                 ready_out, w_out}, 16'h0100, "reset outputs");
      check_val(16'(pc_out), 16'h0000, "reset pc");
      rst_in = 1'b0;
      $display("test reset done");
      issue(6'h03, 1'b0, 6'h01, 7'h05, 8'h00);
      issue(6'h04, 1'b1, 6'h01, 7'h05, 8'h00);
      issue(6'h01, 1'b0, 6'h00, 7'h00, 8'hff);
      issue(6'h02, 1'b0, 6'h00, 7'h00, 8'h00);
      issue(6'h3f, 1'b1, 6'h00, 7'h00, 8'h00);
      issue(6'h03, 1'b1, 6'h3f, 7'h7f, 8'h00);
      idle();
      $display("test directed done");
      for (int n = 0; n < 400; n++) begin
         rnd = $random(seed);
         issue({3'h0, rnd[2:0]}, rnd[3], {6{rnd[4]}},
               rnd[5] ? {7{rnd[6]}} : rnd[13:7], rnd[21:14]);
         if (rnd[24:22] == 3'h0) idle();
      end
      idle();
      $display("test random done");
      complete_run();
   end
endmodule // return_and_rotate_execution_test
